// *** rtl/abbe_pkg.sv ***
package abbe_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PC_W   = 16;

    // Register byte offsets
    localparam logic [7:0] OFF_INSTR  = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ACC    = 8'h08;
    localparam logic [7:0] OFF_BANK   = 8'h0c;
    localparam logic [7:0] OFF_PC     = 8'h10;
    localparam logic [7:0] OFF_FADDR  = 8'h14;
    localparam logic [7:0] OFF_FDATA  = 8'h18;

    // Status field positions
    localparam int ST_C       = 0;
    localparam int ST_DC      = 1;
    localparam int ST_Z       = 2;
    localparam int ST_OV      = 3;
    localparam int ST_N       = 4;
    localparam int ST_BUSY    = 8;
    localparam int ST_ILLEGAL = 9;
    localparam int FLAG_W     = 5;

    // Reset values
    localparam logic [7:0]        RST_ACC    = 8'h00;
    localparam logic [FLAG_W-1:0] RST_FLAGS  = 5'h00;
    localparam logic [3:0]        RST_BANK   = 4'h0;
    localparam logic [PC_W-1:0]   RST_PC     = 16'h0000;
    localparam logic [15:0]       RST_INSTR  = 16'h0000;

    // Opcode prefixes
    localparam logic [5:0] PFX_ADDC = 6'h08;
    localparam logic [7:0] PFX_ANDL = 8'h0b;
    localparam logic [5:0] PFX_ANDF = 6'h05;
    localparam logic [7:0] PFX_BC   = 8'he2;
    localparam logic [3:0] PFX_BCF  = 4'h9;

    // File memory and access bank
    localparam int         MEM_IDX_W   = 10;
    localparam int         MEM_DEPTH   = 1024;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

    // Timing
    localparam logic [1:0] NOP_LAST  = 2'h3;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0002;

    // Responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_Q1   = 6'h02,
        ST_Q2   = 6'h04,
        ST_Q3   = 6'h08,
        ST_Q4   = 6'h10,
        ST_NOP  = 6'h20
    } abbe_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ADDC = 3'h1,
        OP_ANDL = 3'h2,
        OP_ANDF = 3'h3,
        OP_BC   = 3'h4,
        OP_BCF  = 3'h5
    } abbe_op_t;

    typedef struct packed {
        abbe_op_t   op;
        logic       toFile;
        logic       useBank;
        logic [2:0] bitPos;
        logic [7:0] low;
    } abbe_dec_t;

endpackage

// *** rtl/abbe_exec.sv ***
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module abbe_exec (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [abbe_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [abbe_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [abbe_pkg::ADDR_W-1:0]   s_axi_araddr,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [abbe_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               execBusy
);

    abbe_pkg::abbe_state_t                state;
    abbe_pkg::abbe_dec_t                  dec;
    logic [15:0]                          instr;
    logic [7:0]                           acc;
    logic [abbe_pkg::FLAG_W-1:0]          flags;
    logic                                 illegal;
    logic [3:0]                           bank;
    logic [abbe_pkg::PC_W-1:0]            pc;
    logic [11:0]                          fileAddr;
    logic [7:0]                           fileMem [abbe_pkg::MEM_DEPTH];
    logic [7:0]                           operand;
    logic [7:0]                           result;
    logic [abbe_pkg::FLAG_W-1:0]          resFlags;
    logic                                 takeBranch;
    logic [1:0]                           nopCnt;
    logic                                 awHeld;
    logic                                 wHeld;
    logic [abbe_pkg::ADDR_W-1:0]          awAddr;
    logic [abbe_pkg::DATA_W-1:0]          wData;
    logic [3:0]                           wStrb;
    logic                                 doWrite;
    logic                                 wrHit;
    logic                                 startExec;
    logic [11:0]                          effAddr;
    logic [abbe_pkg::MEM_IDX_W-1:0]       effIdx;
    logic [abbe_pkg::MEM_IDX_W-1:0]       fileIdx;
    logic [abbe_pkg::DATA_W-1:0]          rdMux;
    logic                                 rdHit;
    logic [8:0]                           sumFull;
    logic [4:0]                           sumLow;

    function automatic abbe_pkg::abbe_dec_t decode(input logic [15:0] op);
        abbe_pkg::abbe_dec_t d;
        d.op      = abbe_pkg::OP_NONE;
        d.toFile  = op[9];
        d.useBank = op[8];
        d.bitPos  = op[11:9];
        d.low     = op[7:0];
        if (op[15:10] == abbe_pkg::PFX_ADDC) begin
            d.op = abbe_pkg::OP_ADDC;
        end else if (op[15:8] == abbe_pkg::PFX_ANDL) begin
            d.op = abbe_pkg::OP_ANDL;
        end else if (op[15:10] == abbe_pkg::PFX_ANDF) begin
            d.op = abbe_pkg::OP_ANDF;
        end else if (op[15:8] == abbe_pkg::PFX_BC) begin
            d.op = abbe_pkg::OP_BC;
        end else if (op[15:12] == abbe_pkg::PFX_BCF) begin
            d.op = abbe_pkg::OP_BCF;
        end
        return d;
    endfunction

    // Bank resolution for file operands
    function automatic logic [11:0] bankAddr(input logic useBank,
                                             input logic [7:0] f,
                                             input logic [3:0] bank_select_reg);
        logic [3:0] b;
        b = bank_select_reg;
        if (!useBank) begin
            b = (f < abbe_pkg::ACCESS_SPLIT) ? abbe_pkg::ACCESS_LO_BANK
                                             : abbe_pkg::ACCESS_HI_BANK;
        end
        return {b, f};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (data & m);
    endfunction

    function automatic logic [1:0] zeroSign(input logic [7:0] v);
        return {v[7], v == 8'h00};
    endfunction

    assign execBusy      = (state != abbe_pkg::ST_IDLE);
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
    assign wrHit         = doWrite && !execBusy;
    assign startExec     = wrHit && (awAddr == abbe_pkg::OFF_INSTR);
    assign effAddr       = bankAddr(dec.useBank, dec.low, bank);
    assign effIdx        = effAddr[abbe_pkg::MEM_IDX_W-1:0];
    assign fileIdx       = fileAddr[abbe_pkg::MEM_IDX_W-1:0];
    assign sumFull       = {1'b0, acc} + {1'b0, operand}
                           + {8'h00, flags[abbe_pkg::ST_C]};
    assign sumLow        = {1'b0, acc[3:0]} + {1'b0, operand[3:0]}
                           + {4'h0, flags[abbe_pkg::ST_C]};

    // Write address and data latches
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= abbe_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr > abbe_pkg::OFF_FDATA || awAddr[1:0] != 2'h0)
                            ? abbe_pkg::RESP_DECERR : abbe_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path
    always_comb begin
        rdHit = 1'b1;
        rdMux = '0;
        unique case (s_axi_araddr)
            abbe_pkg::OFF_INSTR:  rdMux[15:0] = instr;
            abbe_pkg::OFF_STATUS: begin
                rdMux[abbe_pkg::FLAG_W-1:0] = flags;
                rdMux[abbe_pkg::ST_BUSY]    = execBusy;
                rdMux[abbe_pkg::ST_ILLEGAL] = illegal;
            end
            abbe_pkg::OFF_ACC:    rdMux[7:0] = acc;
            abbe_pkg::OFF_BANK:   rdMux[3:0] = bank;
            abbe_pkg::OFF_PC:     rdMux[abbe_pkg::PC_W-1:0] = pc;
            abbe_pkg::OFF_FADDR:  rdMux[11:0] = fileAddr;
            abbe_pkg::OFF_FDATA:  rdMux[7:0] = fileMem[fileIdx];
            default:              rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= abbe_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdHit ? abbe_pkg::RESP_OKAY
                                  : abbe_pkg::RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Q-phase sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= abbe_pkg::ST_IDLE;
        end else begin
            unique case (state)
                abbe_pkg::ST_IDLE: if (startExec) state <= abbe_pkg::ST_Q1;
                abbe_pkg::ST_Q1:   state <= abbe_pkg::ST_Q2;
                abbe_pkg::ST_Q2:   state <= abbe_pkg::ST_Q3;
                abbe_pkg::ST_Q3:   state <= abbe_pkg::ST_Q4;
                abbe_pkg::ST_Q4:   state <= takeBranch ? abbe_pkg::ST_NOP
                                                       : abbe_pkg::ST_IDLE;
                abbe_pkg::ST_NOP:  if (nopCnt == abbe_pkg::NOP_LAST) begin
                    state <= abbe_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            nopCnt <= '0;
        end else if (state == abbe_pkg::ST_NOP) begin
            nopCnt <= nopCnt + 2'h1;
        end else begin
            nopCnt <= '0;
        end
    end

    // Instruction word and decode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            instr <= abbe_pkg::RST_INSTR;
        end else if (startExec) begin
            instr <= 16'(merge({16'h0000, instr}, wData, wStrb));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dec     <= '0;
            illegal <= 1'b0;
        end else if (state == abbe_pkg::ST_Q1) begin
            dec     <= decode(instr);
        end else if (state == abbe_pkg::ST_Q2) begin
            illegal <= (dec.op == abbe_pkg::OP_NONE);
        end
    end

    // Operand read
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            operand <= '0;
        end else if (state == abbe_pkg::ST_Q2) begin
            operand <= (dec.op == abbe_pkg::OP_ANDL || dec.op == abbe_pkg::OP_BC)
                       ? dec.low : fileMem[effIdx];
        end
    end

    // Process data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result     <= '0;
            resFlags   <= abbe_pkg::RST_FLAGS;
            takeBranch <= 1'b0;
        end else if (state == abbe_pkg::ST_Q3) begin
            resFlags   <= flags;
            takeBranch <= (dec.op == abbe_pkg::OP_BC)
                          && flags[abbe_pkg::ST_C];
            result     <= operand;
            unique case (dec.op)
                abbe_pkg::OP_ADDC: begin
                    result <= sumFull[7:0];
                    resFlags[abbe_pkg::ST_C]  <= sumFull[8];
                    resFlags[abbe_pkg::ST_DC] <= sumLow[4];
                    resFlags[abbe_pkg::ST_OV] <= (acc[7] == operand[7])
                                                 && (sumFull[7] != acc[7]);
                    {resFlags[abbe_pkg::ST_N], resFlags[abbe_pkg::ST_Z]}
                        <= zeroSign(sumFull[7:0]);
                end
                abbe_pkg::OP_ANDL, abbe_pkg::OP_ANDF: begin
                    result <= acc & operand;
                    {resFlags[abbe_pkg::ST_N], resFlags[abbe_pkg::ST_Z]}
                        <= zeroSign(acc & operand);
                end
                abbe_pkg::OP_BCF: begin
                    result <= operand & ~(8'h01 << dec.bitPos);
                end
                default: begin
                end
            endcase
        end
    end

    // Destination write and flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            acc <= abbe_pkg::RST_ACC;
        end else if (state == abbe_pkg::ST_Q4) begin
            if (dec.op == abbe_pkg::OP_ANDL
                || ((dec.op == abbe_pkg::OP_ADDC || dec.op == abbe_pkg::OP_ANDF)
                    && !dec.toFile)) begin
                acc <= result;
            end
        end else if (wrHit && awAddr == abbe_pkg::OFF_ACC) begin
            acc <= 8'(merge({24'h0, acc}, wData, wStrb));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags <= abbe_pkg::RST_FLAGS;
        end else if (state == abbe_pkg::ST_Q4) begin
            flags <= resFlags;
        end else if (wrHit && awAddr == abbe_pkg::OFF_STATUS) begin
            flags <= abbe_pkg::FLAG_W'(merge({27'h0, flags}, wData,
                                             wStrb));
        end
    end

    always_ff @(posedge mclk) begin
        if (state == abbe_pkg::ST_Q4
            && (dec.op == abbe_pkg::OP_BCF
                || ((dec.op == abbe_pkg::OP_ADDC || dec.op == abbe_pkg::OP_ANDF)
                    && dec.toFile))) begin
            fileMem[effIdx] <= result;
        end else if (wrHit && awAddr == abbe_pkg::OFF_FDATA && wStrb[0]) begin
            fileMem[fileIdx] <= wData[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bank <= abbe_pkg::RST_BANK;
        end else if (wrHit && awAddr == abbe_pkg::OFF_BANK) begin
            bank <= 4'(merge({28'h0, bank}, wData, wStrb));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fileAddr <= '0;
        end else if (wrHit && awAddr == abbe_pkg::OFF_FADDR) begin
            fileAddr <= 12'(merge({20'h0, fileAddr}, wData, wStrb));
        end
    end

    // Program counter: step at decode, relative load on a taken branch
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pc <= abbe_pkg::RST_PC;
        end else if (state == abbe_pkg::ST_Q1) begin
            pc <= pc + abbe_pkg::PC_STEP;
        end else if (state == abbe_pkg::ST_Q4 && takeBranch) begin
            pc <= pc + {{7{dec.low[7]}}, dec.low, 1'b0};
        end else if (wrHit && awAddr == abbe_pkg::OFF_PC) begin
            pc <= abbe_pkg::PC_W'(merge({16'h0, pc}, wData, wStrb));
        end
    end

endmodule // abbe_exec

// *** bench/abbe_exec_checker.sv ***
`timescale 1ns/1ps
module abbe_exec_checker (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       execBusy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic [3:0] runLen;
    logic [7:0] wrAddr;
    logic       bothIn;
    logic       instrGo;
    assign bothIn = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                    && s_axi_wready;
    assign instrGo = bothIn && !execBusy
                     && s_axi_awaddr == abbe_pkg::OFF_INSTR;
    // Length of the current busy run
    always_ff @(posedge mclk) begin
        if (sys_rst || !execBusy) begin
            runLen <= 4'h0;
        end else if (runLen != 4'hf) begin
            runLen <= runLen + 4'h1;
        end
    end
    // Address of the write in flight
    always_ff @(posedge mclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            wrAddr <= s_axi_awaddr;
        end
    end
    chk_write_answer: assert property (bothIn |-> ##2 s_axi_bvalid)
        else $error("no write response after address and data");
    chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp ==
        ((wrAddr[1:0] == 2'h0 && wrAddr <= abbe_pkg::OFF_FDATA)
        ? abbe_pkg::RESP_OKAY : abbe_pkg::RESP_DECERR))
        else $error("write response code wrong for address");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_aw_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready during response");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("no read data after address");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid)
        else $error("read data dropped early");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready during read data");
    chk_busy_start: assert property (instrGo |=> ##[0:1] execBusy)
        else $error("instruction write did not start execution");
    chk_busy_min: assert property ($rose(execBusy) |-> execBusy[*4])
        else $error("execution shorter than four cycles");
    chk_busy_len: assert property ($fell(execBusy)
        |-> runLen == 4'h4 || runLen == 4'h8)
        else $error("execution length not four or eight cycles");
    cov_taken: cover property ($fell(execBusy) && runLen == 4'h8);
    cov_single: cover property ($fell(execBusy) && runLen == 4'h4);
    cov_decerr: cover property (s_axi_bvalid
        && s_axi_bresp == abbe_pkg::RESP_DECERR);
endmodule // abbe_exec_checker

bind abbe_exec abbe_exec_checker i_abbe_exec_checker (
    .mclk(mclk), .sys_rst(sys_rst), .execBusy(execBusy),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// *** bench/abbe_exec_bench.sv ***
`timescale 1ns/1ps
module abbe_exec_bench;
    logic        mclk, sys_rst, execBusy;
    logic        awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp;
    int          failCount, testsRun;

    abbe_exec i_abbe_exec (
        .mclk(mclk), .sys_rst(sys_rst), .execBusy(execBusy),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic completeRun;
        $display("Checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One clock with a bound on the wait
    task automatic step(inout int n);
        @(posedge mclk);
        n++;
        if (n > 60) begin
            failCount++;
            $display("[ERR] wait expected handshake seen timeout");
            completeRun();
        end
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        awAddr  <= a;
        wData   <= d;
        wStrb   <= s;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        do begin
            step(n);
            if (awReady === 1'b1) awValid <= 1'b0;
            if (wReady === 1'b1) wValid <= 1'b0;
        end while (bValid !== 1'b1);
        r = bResp;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
        int n;
        n = 0;
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do begin
            step(n);
            if (arReady === 1'b1) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        d = rData;
        r = rResp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axiWrite(a, d, 4'hf, r);
        check("write response", {30'h0, abbe_pkg::RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rdChk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axiRead(a, d, r);
        check(what, exp, d);
        check("read response", {30'h0, abbe_pkg::RESP_OKAY}, {30'h0, r});
    endtask

    task automatic setFile(input logic [11:0] fa, input logic [7:0] d);
        wr(abbe_pkg::OFF_FADDR, {20'h0, fa});
        wr(abbe_pkg::OFF_FDATA, {24'h0, d});
    endtask

    task automatic fileChk(input logic [11:0] fa, input logic [7:0] d);
        wr(abbe_pkg::OFF_FADDR, {20'h0, fa});
        rdChk("file byte", abbe_pkg::OFF_FDATA, {24'h0, d});
    endtask

    task automatic setCore(input logic [7:0] acc, input logic [7:0] st,
                           input logic [3:0] bank);
        wr(abbe_pkg::OFF_ACC, {24'h0, acc});
        wr(abbe_pkg::OFF_STATUS, {24'h0, st});
        wr(abbe_pkg::OFF_BANK, {28'h0, bank});
    endtask

    task automatic coreChk(input logic [7:0] acc, input logic [7:0] st);
        rdChk("accumulator", abbe_pkg::OFF_ACC, {24'h0, acc});
        rdChk("status", abbe_pkg::OFF_STATUS, {24'h0, st});
    endtask

    // Start an instruction and measure its busy run
    task automatic runInstr(input logic [15:0] ins, input int cyc);
        int n;
        int len;
        wr(abbe_pkg::OFF_INSTR, {16'h0, ins});
        n = 0;
        len = 0;
        while (execBusy !== 1'b1) step(n);
        while (execBusy === 1'b1) begin
            step(n);
            len++;
        end
        check("busy cycles", cyc, len);
    endtask

    task automatic testReset;
        logic [31:0] d;
        logic [1:0]  r;
        coreChk(8'h00, 8'h00);
        rdChk("bank", abbe_pkg::OFF_BANK, 32'h0);
        rdChk("counter", abbe_pkg::OFF_PC, 32'h0);
        axiRead(8'h40, d, r);
        check("unmapped read", {30'h0, abbe_pkg::RESP_DECERR}, {30'h0, r});
        axiWrite(8'h44, 32'h1, 4'hf, r);
        check("unmapped write", {30'h0, abbe_pkg::RESP_DECERR}, {30'h0, r});
        setFile(12'h000, 8'h5a);
        axiWrite(abbe_pkg::OFF_FDATA, 32'ha5, 4'he, r);
        fileChk(12'h000, 8'h5a);
    endtask

    task automatic testAndLit;
        setCore(8'ha3, 8'h01, 4'h0);
        runInstr(16'h0b5f, 4);
        coreChk(8'h03, 8'h01);
        runInstr(16'h0b00, 4);
        coreChk(8'h00, 8'h05);
        setCore(8'hf0, 8'h00, 4'h0);
        runInstr(16'h0b80, 4);
        coreChk(8'h80, 8'h10);
    endtask

    task automatic testAndFile;
        setCore(8'h17, 8'h01, 4'h2);
        setFile(12'h010, 8'hc2);
        setFile(12'h210, 8'h3c);
        setFile(12'hf90, 8'hff);
        runInstr(16'h1410, 4);
        coreChk(8'h02, 8'h01);
        fileChk(12'h010, 8'hc2);
        runInstr(16'h1710, 4);
        fileChk(12'h210, 8'h00);
        coreChk(8'h02, 8'h05);
        runInstr(16'h1690, 4);
        fileChk(12'hf90, 8'h02);
        coreChk(8'h02, 8'h01);
    endtask

    task automatic testAddc;
        setCore(8'h4d, 8'h01, 4'h1);
        setFile(12'h120, 8'h02);
        runInstr(16'h2120, 4);
        coreChk(8'h50, 8'h02);
        fileChk(12'h120, 8'h02);
        setCore(8'hff, 8'h00, 4'h1);
        setFile(12'h020, 8'h01);
        runInstr(16'h2220, 4);
        fileChk(12'h020, 8'h00);
        coreChk(8'hff, 8'h07);
    endtask

    task automatic testBranch;
        logic [7:0]  off[4] = '{8'h05, 8'h05, 8'h80, 8'h7f};
        logic        cin[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic [15:0] pcx;
        for (int i = 0; i < 4; i++) begin
            setCore(8'h00, {3'h0, 4'hf, cin[i]}, 4'h0);
            wr(abbe_pkg::OFF_PC, 32'h0100);
            pcx = 16'h0102;
            if (cin[i]) pcx = pcx + {{7{off[i][7]}}, off[i], 1'b0};
            runInstr({8'he2, off[i]}, cin[i] ? 8 : 4);
            rdChk("counter", abbe_pkg::OFF_PC, {16'h0, pcx});
            coreChk(8'h00, {3'h0, 4'hf, cin[i]});
        end
    endtask

    task automatic testBitClear;
        setCore(8'h00, 8'h1f, 4'h3);
        setFile(12'h320, 8'hc7);
        runInstr(16'h9f20, 4);
        fileChk(12'h320, 8'h47);
        coreChk(8'h00, 8'h1f);
        for (int b = 0; b < 8; b++) begin
            setFile(12'h010, 8'hff);
            runInstr({4'h9, 3'(b), 1'b0, 8'h10}, 4);
            fileChk(12'h010, ~(8'h01 << b));
        end
        runInstr(16'hffff, 4);
        rdChk("status", abbe_pkg::OFF_STATUS, 32'h0000021f);
    endtask

    initial begin
        failCount = 0;
        testsRun  = 0;
        sys_rst   = 1'b1;
        {awValid, wValid, bReady, arValid, rReady} = 5'h00;
        awAddr = 8'h00;
        arAddr = 8'h00;
        wData  = 32'h0;
        wStrb  = 4'hf;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        testReset();
        testAndLit();
        testAndFile();
        testAddc();
        testBranch();
        testBitClear();
        completeRun();
    end
endmodule // abbe_exec_bench
